// >>> verilog/sei_pkg.sv
// Shared constants and types of the sync event interrupt masking block.
// Assumes an 8-bit register model mapped onto a 32-bit Wishbone word bus.
package sei_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_UPPER_FLAGS  = 6'h08;
  localparam logic [5:0] IDX_INPUT_EN     = 6'h09;
  localparam logic [5:0] IDX_LOOP1_EN     = 6'h0A;
  localparam logic [5:0] IDX_LOOP2_EN     = 6'h0B;
  localparam logic [5:0] IDX_LOWER_QUAL   = 6'h0C;
  localparam logic [5:0] IDX_LOOP1_FLAGS  = 6'h20;
  localparam logic [5:0] IDX_LOOP2_FLAGS  = 6'h21;

  // Byte address bits that carry the index
  localparam int ADR_IDX_LO = 2;
  localparam int ADR_IDX_HI = 7;

  // Reset values
  localparam logic [7:0] RST_INPUT_EN   = 8'h00;
  localparam logic [7:0] RST_LOOP1_EN   = 8'h00;
  localparam logic [7:0] RST_LOOP2_EN   = 8'h00;
  localparam logic [7:0] RST_LOWER_QUAL = 8'hFF;

  // Writable bits; reserved bits read as zero
  localparam logic [7:0] LOOP1_EN_WMASK = 8'h7F;
  localparam logic [7:0] LOOP2_EN_WMASK = 8'h0F;

  // Field positions
  localparam int LOOP1_EVT_W   = 6;
  localparam int LOOP2_EVT_W   = 4;
  localparam int NIBBLE_W      = 4;
  localparam int INPUT0_QUAL_LO = 0;
  localparam int INPUT1_QUAL_LO = 4;
  localparam int INPUT6_FLAG_LO = 0;
  localparam int INPUT7_FLAG_LO = 4;
  localparam int REF_COUNT     = 8;
  localparam int LOWER_REFS    = 6;
  localparam int INPUT6_EN_BIT = 6;
  localparam int INPUT7_EN_BIT = 7;

  // Monitor order within a nibble
  localparam int MON_CYCLE   = 0;
  localparam int MON_COARSE  = 1;
  localparam int MON_SOAK    = 2;
  localparam int MON_PRECISE = 3;

  // Loop events, highest bit first
  typedef struct packed {
    logic [1:0] sync_fail;
    logic       ref_changed;
    logic       holdover;
    logic       lost_lock;
    logic       locked;
  } sei_loop1_evt_t;

  typedef struct packed {
    logic ref_changed;
    logic holdover;
    logic lost_lock;
    logic locked;
  } sei_loop2_evt_t;

  // Monitor faults for one input, highest bit first
  typedef struct packed {
    logic precise_freq_fault;
    logic soak_fault;
    logic coarse_freq_fault;
    logic cycle_fault;
  } sei_mon_fault_t;

endpackage

// >>> verilog/sei_sticky.sv
// Sticky flag bank: set by hardware pulses, cleared bit-wise by a read.
// Assumes the clear vector holds only bits that software has seen.
`timescale 1ns/1ps
module sei_sticky #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Set wins over a clear in the same cycle
  assign q_nxt = (q_r & ~clr) | set;
  assign q     = q_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

endmodule

// >>> verilog/sei_irq_mask.sv
// Interrupt enables, monitor qualify masks and sticky event flags.
// Assumes event inputs are one-cycle pulses on the same clock.
//
// Notes on behaviour
// R1 - An eight-bit input failure enable, bit n for input n, zero blocks, reset 0x00.
// R2 - First loop enable bits 0..3 gate locked, lost-lock, holdover, ref-changed, 5:4 sync fail.
// R3 - In both loop enables a one allows and a zero blocks, and both reset to zero.
// R4 - Second loop enable uses bits 3:0 in event order, bits 7:4 reserved.
// R5 - Input 0 monitor qualify sits in bits 3:0 of a register that resets to all ones.
// R6 - Input 1 monitor qualify sits in bits 7:4 with the same layout and polarity.
// R7 - Nibble bits map to cycle, coarse, soak and precise monitors; zero masks the monitor.
// R8 - Inputs 6 and 7 monitor fault flags read as one on failure, low and high nibble.
// R9 - Loop event flags set on their event and clear when their register is read.
// R10 - Fault flags stay set until read; irq is high while an enabled flag is set. The code registers irq, so it rises and falls one cycle after the flags.
`timescale 1ns/1ps
module sei_irq_mask (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire sei_pkg::sei_mon_fault_t input6_fault,
  input  wire sei_pkg::sei_mon_fault_t input7_fault,
  input  wire logic [5:0]              lower_inputs_failed,
  input  wire sei_pkg::sei_loop1_evt_t first_loop_evt,
  input  wire sei_pkg::sei_loop2_evt_t second_loop_evt,
  output logic      [3:0]              input0_monitor_qualify,
  output logic      [3:0]              input1_monitor_qualify,
  output logic                         irq
);

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // Bus decode
  logic        ack_r;
  logic [31:0] dat_r;
  logic [7:0]  input_en_r;
  logic [7:0]  loop1_en_r;
  logic [7:0]  loop2_en_r;
  logic [7:0]  lower_qual_r;
  logic [7:0]  upper_flags;
  logic [5:0]  loop1_flags;
  logic [3:0]  loop2_flags;

  wire       req      = wb_cyc_i & wb_stb_i;
  wire [5:0] idx      = wb_adr_i[sei_pkg::ADR_IDX_HI:sei_pkg::ADR_IDX_LO];
  wire       wr_fire  = req & ack_r & wb_we_i & wb_sel_i[0];
  wire       rd_fire  = req & ack_r & ~wb_we_i;
  wire       hit_upf  = (idx == sei_pkg::IDX_UPPER_FLAGS);
  wire       hit_ien  = (idx == sei_pkg::IDX_INPUT_EN);
  wire       hit_l1e  = (idx == sei_pkg::IDX_LOOP1_EN);
  wire       hit_l2e  = (idx == sei_pkg::IDX_LOOP2_EN);
  wire       hit_qual = (idx == sei_pkg::IDX_LOWER_QUAL);
  wire       hit_l1f  = (idx == sei_pkg::IDX_LOOP1_FLAGS);
  wire       hit_l2f  = (idx == sei_pkg::IDX_LOOP2_FLAGS);

  // Read mux; unmapped indices read zero
  logic [7:0] rd_byte;
  always_comb
  begin
    if (hit_upf)
      rd_byte = upper_flags;
    else if (hit_ien)
      rd_byte = input_en_r;
    else if (hit_l1e)
      rd_byte = loop1_en_r;
    else if (hit_l2e)
      rd_byte = loop2_en_r;
    else if (hit_qual)
      rd_byte = lower_qual_r;
    else if (hit_l1f)
      rd_byte = {2'h0, loop1_flags};
    else if (hit_l2f)
      rd_byte = {4'h0, loop2_flags};
    else
      rd_byte = 8'h00;
  end

  // One wait state: ack and data registered, ack drops after one cycle
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Control registers
  wire [7:0] wr_byte = wb_dat_i[7:0];

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      input_en_r   <= sei_pkg::RST_INPUT_EN;
      loop1_en_r   <= sei_pkg::RST_LOOP1_EN;
      loop2_en_r   <= sei_pkg::RST_LOOP2_EN;
      lower_qual_r <= sei_pkg::RST_LOWER_QUAL;
    end
    else if (wr_fire)
    begin
      // R1 input enable write
      if (hit_ien)
        input_en_r <= wr_byte;
      // R2 R4 reserved bits kept zero
      if (hit_l1e)
        loop1_en_r <= wr_byte & sei_pkg::LOOP1_EN_WMASK;
      if (hit_l2e)
        loop2_en_r <= wr_byte & sei_pkg::LOOP2_EN_WMASK;
      // R5 R6 qualify masks
      if (hit_qual)
        lower_qual_r <= wr_byte;
    end
  end

  // R5 R6 R7 nibbles drive the monitors
  assign input0_monitor_qualify = lower_qual_r[sei_pkg::INPUT0_QUAL_LO +: sei_pkg::NIBBLE_W];
  assign input1_monitor_qualify = lower_qual_r[sei_pkg::INPUT1_QUAL_LO +: sei_pkg::NIBBLE_W];

  // Clear only bits that were returned by the acked read
  wire [7:0] upf_clr = (rd_fire & hit_upf) ? dat_r[7:0] : 8'h00;
  wire [5:0] l1f_clr = (rd_fire & hit_l1f) ? dat_r[5:0] : 6'h00;
  wire [3:0] l2f_clr = (rd_fire & hit_l2f) ? dat_r[3:0] : 4'h0;

  // R8 R10 monitor fault flags
  sei_sticky #(
    .W (8)
  ) u_upper_flags (
    .clock (clock),
    .rst_n (rst_sync_n),
    .set   ({input7_fault, input6_fault}),
    .clr   (upf_clr),
    .q     (upper_flags)
  );

  // R9 first loop event flags
  sei_sticky #(
    .W (sei_pkg::LOOP1_EVT_W)
  ) u_loop1_flags (
    .clock (clock),
    .rst_n (rst_sync_n),
    .set   (first_loop_evt),
    .clr   (l1f_clr),
    .q     (loop1_flags)
  );

  // R9 second loop event flags
  sei_sticky #(
    .W (sei_pkg::LOOP2_EVT_W)
  ) u_loop2_flags (
    .clock (clock),
    .rst_n (rst_sync_n),
    .set   (second_loop_evt),
    .clr   (l2f_clr),
    .q     (loop2_flags)
  );

  // Per-input failure, then gated by its enable
  wire       input6_any = |upper_flags[sei_pkg::INPUT6_FLAG_LO +: sei_pkg::NIBBLE_W];
  wire       input7_any = |upper_flags[sei_pkg::INPUT7_FLAG_LO +: sei_pkg::NIBBLE_W];
  wire [7:0] input_fail = {input7_any, input6_any, lower_inputs_failed};
  // R1 R10 input failure gating
  wire       input_irq  = |(input_fail & input_en_r);
  // R2 R3 R4 loop event gating
  wire       loop1_irq  = |(loop1_flags & loop1_en_r[sei_pkg::LOOP1_EVT_W-1:0]);
  wire       loop2_irq  = |(loop2_flags & loop2_en_r[sei_pkg::LOOP2_EVT_W-1:0]);

  logic irq_r;
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      irq_r <= 1'b0;
    else
      irq_r <= input_irq | loop1_irq | loop2_irq;
  end

  // R10 level interrupt
  assign irq = irq_r;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n);

  property p_input_en_write;
    (wr_fire && hit_ien) |=> (input_en_r == $past(wb_dat_i[7:0]));
  endproperty
  a_input_en_write: assert property (p_input_en_write) // R1
    else $error("input enable write not stored");

  property p_input_gate;
    (input_en_r[sei_pkg::INPUT6_EN_BIT] == 1'b0 && input_en_r[sei_pkg::INPUT7_EN_BIT] == 1'b0
      && input_en_r[5:0] == 6'h00 && loop1_irq == 1'b0 && loop2_irq == 1'b0)
      |=> !irq;
  endproperty
  a_input_gate: assert property (p_input_gate) // R1
    else $error("irq raised with all enables zero");

  property p_loop1_reserved;
    loop1_en_r[7] == 1'b0;
  endproperty
  a_loop1_reserved: assert property (p_loop1_reserved) // R2
    else $error("first loop reserved bit set");

  property p_loop_en_reset;
    $rose(rst_sync_n) |-> (loop1_en_r == 8'h00 && loop2_en_r == 8'h00 && input_en_r == 8'h00);
  endproperty
  a_loop_en_reset: assert property (p_loop_en_reset) // R3
    else $error("enable reset value wrong");

  property p_loop2_reserved;
    loop2_en_r[7:4] == 4'h0;
  endproperty
  a_loop2_reserved: assert property (p_loop2_reserved) // R4
    else $error("second loop reserved bits set");

  property p_qual_reset;
    $rose(rst_sync_n) |-> (input0_monitor_qualify == 4'hF && input1_monitor_qualify == 4'hF);
  endproperty
  a_qual_reset: assert property (p_qual_reset) // R5
    else $error("qualify reset not all ones");

  property p_qual_write;
    (wr_fire && hit_qual) |=> (input1_monitor_qualify == $past(wb_dat_i[7:4])
      && input0_monitor_qualify == $past(wb_dat_i[3:0]));
  endproperty
  a_qual_write: assert property (p_qual_write) // R6
    else $error("qualify nibbles misplaced");

  property p_mon_order;
    input6_fault.soak_fault |=> upper_flags[sei_pkg::MON_SOAK];
  endproperty
  a_mon_order: assert property (p_mon_order) // R7
    else $error("soak fault not in bit 2");

  property p_upper_read;
    (req && !ack_r && !wb_we_i && hit_upf) |=> (wb_ack_o && wb_dat_o[7:0] == $past(upper_flags));
  endproperty
  a_upper_read: assert property (p_upper_read) // R8
    else $error("fault flags read wrong");

  property p_loop1_clear;
    (rd_fire && hit_l1f && first_loop_evt == 6'h00)
      |=> ((loop1_flags & $past(dat_r[5:0])) == 6'h00);
  endproperty
  a_loop1_clear: assert property (p_loop1_clear) // R9
    else $error("first loop flags not cleared by read");

  property p_loop2_clear;
    (rd_fire && hit_l2f && second_loop_evt == 4'h0)
      |=> ((loop2_flags & $past(dat_r[3:0])) == 4'h0);
  endproperty
  a_loop2_clear: assert property (p_loop2_clear) // R9
    else $error("second loop flags not cleared by read");

  property p_input7_map;
    input7_fault.precise_freq_fault
      |=> upper_flags[sei_pkg::INPUT7_FLAG_LO + sei_pkg::MON_PRECISE];
  endproperty
  a_input7_map: assert property (p_input7_map) // R8
    else $error("input 7 precise fault not in bit 7");

  property p_sticky_hold;
    (upper_flags[sei_pkg::MON_PRECISE] && !(rd_fire && hit_upf))
      |=> upper_flags[sei_pkg::MON_PRECISE];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) // R10
    else $error("fault flag dropped without read");

  property p_irq_loop;
    (loop1_flags[0] && loop1_en_r[0]) |=> irq;
  endproperty
  a_irq_loop: assert property (p_irq_loop) // R10
    else $error("enabled locked event gave no irq");

  c_write: cover property (wr_fire && hit_l1e);
  c_read_clear: cover property (rd_fire && hit_l2f && loop2_flags != 4'h0);
  c_irq_rise: cover property ($rose(irq));
  c_set_on_clear: cover property (rd_fire && hit_upf && input7_fault != 4'h0);

endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the sync event interrupt masking block.
// Drives the Wishbone port and all event inputs itself; no far-side model.
`timescale 1ns/1ps
module tb_top;
  logic                    clock;
  logic                    rstn;
  logic                    cyc;
  logic                    stb;
  logic                    we;
  logic [7:0]              adr;
  logic [3:0]              sel;
  logic [31:0]             dat;
  logic [31:0]             dat_o;
  logic                    ack;
  sei_pkg::sei_mon_fault_t f6;
  sei_pkg::sei_mon_fault_t f7;
  logic [5:0]              low_f;
  sei_pkg::sei_loop1_evt_t e1;
  sei_pkg::sei_loop2_evt_t e2;
  logic [3:0]              q0;
  logic [3:0]              q1;
  logic                    irq;
  logic [31:0]             rd;
  int                      fails;
  int                      checks_done;
  int                      cycles;

  sei_irq_mask uut (
    .clock                  (clock),
    .rstn                   (rstn),
    .wb_cyc_i               (cyc),
    .wb_stb_i               (stb),
    .wb_we_i                (we),
    .wb_adr_i               (adr),
    .wb_sel_i               (sel),
    .wb_dat_i               (dat),
    .wb_dat_o               (dat_o),
    .wb_ack_o               (ack),
    .input6_fault           (f6),
    .input7_fault           (f7),
    .lower_inputs_failed    (low_f),
    .first_loop_evt         (e1),
    .second_loop_evt        (e2),
    .input0_monitor_qualify (q0),
    .input1_monitor_qualify (q1),
    .irq                    (irq)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      finish_test;
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic cycle; request held until the edge that samples ack
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h000000, d};
    // Ack and data seen as sampled at the edge; a hang ends by the cycle limit
    @(posedge clock);
    while (ack !== 1'b1)
      @(posedge clock);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, 4'hF, d);
  endtask

  task rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 4'hF, 8'h00);
    chk(name, {24'h000000, exp}, rd);
  endtask

  task settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  // Kind 0 first loop, 1 second loop, 2 input 6, 3 input 7
  task pulse(input int k, input int i);
    @(posedge clock);
    case (k)
      0: e1 <= sei_pkg::sei_loop1_evt_t'(6'h01 << i);
      1: e2 <= sei_pkg::sei_loop2_evt_t'(4'h1 << i);
      2: f6 <= sei_pkg::sei_mon_fault_t'(4'h1 << i);
      default: f7 <= sei_pkg::sei_mon_fault_t'(4'h1 << i);
    endcase
    @(posedge clock);
    e1 <= '0;
    e2 <= '0;
    f6 <= '0;
    f7 <= '0;
  endtask

  task ev(input int k, input int i);
    logic [7:0] en_a;
    logic [7:0] fl_a;
    logic [7:0] en_v;
    logic [7:0] fl_v;
    en_a = (k == 0) ? 8'h28 : (k == 1) ? 8'h2C : 8'h24;
    fl_a = (k == 0) ? 8'h80 : (k == 1) ? 8'h84 : 8'h20;
    en_v = (k < 2) ? (8'h01 << i) : (8'h40 << (k - 2));
    fl_v = (k == 3) ? (8'h10 << i) : (8'h01 << i);
    wr(en_a, 8'h00);
    pulse(k, i);
    settle;
    chk("irq masked", 32'h0, irq);
    wr(en_a, en_v);
    settle;
    chk("irq enabled", 32'h1, irq);
    rchk("event flags", fl_a, fl_v);
    rchk("flags cleared", fl_a, 8'h00);
    settle;
    chk("irq cleared", 32'h0, irq);
  endtask

  initial
  begin
    rstn = 1'b0;
    {cyc, stb, we, adr, sel, dat, low_f} = '0;
    {f6, f7, e1, e2} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rchk("input enable", 8'h24, 8'h00);
    rchk("loop1 enable", 8'h28, 8'h00);
    rchk("loop2 enable", 8'h2C, 8'h00);
    rchk("qualify reg", 8'h30, 8'hFF);
    chk("qualify0", 32'hF, q0);
    chk("qualify1", 32'hF, q1);
    chk("irq idle", 32'h0, irq);
    $display("test reset done");
    wr(8'h24, 8'hA5);
    rchk("input enable", 8'h24, 8'hA5);
    wr(8'h28, 8'hFF);
    rchk("loop1 enable", 8'h28, 8'h7F);
    wr(8'h2C, 8'hFF);
    rchk("loop2 enable", 8'h2C, 8'h0F);
    bus(1'b1, 8'h24, 4'h0, 8'h00);
    rchk("no sel write", 8'h24, 8'hA5);
    rchk("unmapped", 8'h3C, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h30, ~(8'h11 << m));
      @(negedge clock);
      chk("qualify0", {28'h0, ~(4'h1 << m)}, q0);
      chk("qualify1", {28'h0, ~(4'h1 << m)}, q1);
    end
    wr(8'h30, 8'h5A);
    @(negedge clock);
    chk("qualify0", 32'hA, q0);
    chk("qualify1", 32'h5, q1);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
      ev(0, i);
    for (int i = 0; i < 4; i++)
    begin
      ev(1, i);
      ev(2, i);
      ev(3, i);
    end
    $display("test events done");
    for (int n = 0; n < 6; n++)
    begin
      wr(8'h24, 8'h00);
      @(posedge clock);
      low_f <= 6'h01 << n;
      settle;
      chk("irq masked", 32'h0, irq);
      wr(8'h24, 8'h01 << n);
      settle;
      chk("irq enabled", 32'h1, irq);
      @(posedge clock);
      low_f <= 6'h00;
      settle;
      chk("irq cleared", 32'h0, irq);
    end
    $display("test lower inputs done");
    finish_test;
  end
endmodule
